// [core/pin_select_pkg.sv]
// Constants shared by the external bus pin function select block.
// Assumes a 32-bit APB register port and eight multiplexed port pins.
package pin_select_pkg;

  // ==========================================================
  // Sizes
  localparam int ADDR_W      = 8;   // APB address width
  localparam int DATA_W      = 32;  // APB data width
  localparam int NUM_PINS    = 8;   // Multiplexed pins handled here
  localparam int NUM_HI_ADDR = 4;   // Upper address pins
  localparam int NUM_CAPTURE = 6;   // Capture trigger taps

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;  // Bus mode and strobe enables
  localparam logic [7:0] OFF_HIGH_ADDRESS_OUTPUT_CONTROL = 8'h04;  // High address output control
  localparam logic [7:0] OFF_DATA = 8'h08;  // Port output data
  localparam logic [7:0] OFF_DIR  = 8'h0c;  // Port direction, 1 = output
  localparam logic [7:0] OFF_PULL = 8'h10;  // Pull-up select
  localparam logic [7:0] OFF_PINS = 8'h14;  // Pin levels and ownership, read only

  // ==========================================================
  // Control register fields
  localparam int CTRL_EXT_BIT   = 0;  // External bus enabled
  localparam int CTRL_B16_BIT   = 1;  // 16-bit external bus
  localparam int CTRL_WSLO_BIT  = 2;  // Low byte write strobe output enable
  localparam int CTRL_WSHI_BIT  = 3;  // High byte write strobe output enable
  localparam int CTRL_W         = 4;  // Implemented control bits
  localparam int PINS_OWN_LSB   = 8;  // Ownership field position in OFF_PINS

  // ==========================================================
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;   // Single-chip mode
  localparam logic [3:0] HIGH_ADDRESS_OUTPUT_CONTROL_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;  // All pins input
  localparam logic [7:0] PULL_RST = 8'h00;

  // ==========================================================
  // Pin positions within the eight-pin group
  localparam int PIN_ALE  = 4;  // Latch strobe port bit
  localparam int PIN_RD   = 5;  // Read strobe port bit
  localparam int PIN_WSLO = 6;  // Low write port bit
  localparam int PIN_WSHI = 7;  // High write port bit

endpackage

// [core/pin_sel_if.sv]
// Carrier between the register side and the pin multiplexer.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pin_sel_if;
  logic                                      ext_en;      // External bus mode
  logic                                      bus_16bit;   // 16-bit bus width
  logic                                      wslo_en;     // Low write strobe enable
  logic                                      wshi_en;     // High write strobe enable
  logic [pin_select_pkg::NUM_HI_ADDR-1:0]    high_address_output_control;
  logic [pin_select_pkg::NUM_PINS-1:0]       pdata;       // Port output data
  logic [pin_select_pkg::NUM_PINS-1:0]       pdir;        // Port direction
  logic [pin_select_pkg::NUM_HI_ADDR-1:0]    addr_hi;     // Bus address bits 20..23
  logic                                      ale;         // Bus latch strobe
  logic                                      rd;          // Bus read strobe
  logic                                      write;       // Bus write strobe
  logic                                      lane_lo;     // Low byte lane active
  logic                                      lane_hi;     // High byte lane active
  logic [pin_select_pkg::NUM_PINS-1:0]       sel_out;     // Chosen pin level
  logic [pin_select_pkg::NUM_PINS-1:0]       sel_oe;      // Chosen drive enable
  logic [pin_select_pkg::NUM_PINS-1:0]       sel_port;    // 1 = port function owns

  modport ctrl (output ext_en, bus_16bit, wslo_en, wshi_en, high_address_output_control,
                output pdata, pdir, addr_hi, ale, rd, write, lane_lo, lane_hi,
                input  sel_out, sel_oe, sel_port);
  modport mux  (input  ext_en, bus_16bit, wslo_en, wshi_en, high_address_output_control,
                input  pdata, pdir, addr_hi, ale, rd, write, lane_lo, lane_hi,
                output sel_out, sel_oe, sel_port);
endinterface
`default_nettype wire

// [core/pin_mux.sv]
// Combinational pin function selector for the eight multiplexed pins.
// Assumes the caller registers the results before they reach the pads.
`timescale 1ns/1ps
`default_nettype none
module pin_mux (
  pin_sel_if.mux sel
);

  // ==========================================================
  // Ownership and bus function per pin
  wire [pin_select_pkg::NUM_PINS-1:0] own;   // Port function selected
  wire [pin_select_pkg::NUM_PINS-1:0] func;  // Bus function level

  genvar i;
  generate
    // Upper address pins: port when the control bit is one
    for (i = 0; i < pin_select_pkg::NUM_HI_ADDR; i++) begin : g_addr
      assign own[i]  = !sel.ext_en || sel.high_address_output_control[i];
      assign func[i] = sel.addr_hi[i];
    end
  endgenerate

  // Latch and read strobes take the pin whenever the bus is on
  assign own[pin_select_pkg::PIN_ALE]  = !sel.ext_en;
  assign func[pin_select_pkg::PIN_ALE] = sel.ale;
  assign own[pin_select_pkg::PIN_RD]   = !sel.ext_en;
  assign func[pin_select_pkg::PIN_RD]  = sel.rd;

  // Low strobe covers the low lane on a 16-bit bus, every write on 8-bit
  assign own[pin_select_pkg::PIN_WSLO]  = !(sel.ext_en && sel.wslo_en);
  assign func[pin_select_pkg::PIN_WSLO] = sel.bus_16bit ? (sel.write && sel.lane_lo)
                                                        : sel.write;

  // High strobe needs all three conditions; otherwise the port keeps the pin
  assign own[pin_select_pkg::PIN_WSHI]  = !(sel.ext_en && sel.bus_16bit && sel.wshi_en);
  assign func[pin_select_pkg::PIN_WSHI] = sel.write && sel.lane_hi;

  // ==========================================================
  // Final mux: a bus function always drives its pin
  generate
    for (i = 0; i < pin_select_pkg::NUM_PINS; i++) begin : g_pin
      assign sel.sel_out[i]  = own[i] ? sel.pdata[i] : func[i];
      assign sel.sel_oe[i]   = own[i] ? sel.pdir[i]  : 1'b1;
      assign sel.sel_port[i] = own[i];
    end
  endgenerate

endmodule // pin_mux
`default_nettype wire

// [core/ext_bus_pin_select.sv]
// Pin function select for upper address and bus strobe pins, with APB registers.
// Assumes bus controller strobes and pad inputs are synchronous to sys_clk.
//
// Function
// - Address pin is port when control bit one
// - Address pin drives address bit when zero in bus mode
// - Latch and read port only in single-chip
// - Bus mode drives latch strobe on pin
// - Bus mode drives read strobe on pin
// - Low write pin port unless bus strobe on
// - Low strobe needs bus and enable together
// - Low strobe: low lane 16-bit, all 8-bit
// - High write pin port unless bus strobe on
// - High strobe needs bus, 16-bit, enable
// - Each pin has software pull-up select
// - Pins feed capture triggers 0 to 5
`timescale 1ns/1ps
`default_nettype none
module ext_bus_pin_select (
  input  wire  logic                                     sys_clk,
  input  wire  logic                                     rst,
  // APB slave
  input  wire  logic                                     psel,
  input  wire  logic                                     penable,
  input  wire  logic                                     pwrite,
  input  wire  logic [pin_select_pkg::ADDR_W-1:0]        paddr,
  input  wire  logic [pin_select_pkg::DATA_W-1:0]        pwdata,
  output logic       [pin_select_pkg::DATA_W-1:0]        prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  // Internal external-bus controller
  input  wire  logic [pin_select_pkg::NUM_HI_ADDR-1:0]   bus_addr_hi,
  input  wire  logic                                     bus_ale,
  input  wire  logic                                     bus_rd,
  input  wire  logic                                     bus_write,
  input  wire  logic                                     bus_lane_lo,
  input  wire  logic                                     bus_lane_hi,
  // Pads
  input  wire  logic [pin_select_pkg::NUM_PINS-1:0]      pin_in,
  output logic       [pin_select_pkg::NUM_PINS-1:0]      pin_out,
  output logic       [pin_select_pkg::NUM_PINS-1:0]      pin_oe,
  output logic       [pin_select_pkg::NUM_PINS-1:0]      pin_pullup,
  // Trigger taps
  output logic       [pin_select_pkg::NUM_CAPTURE-1:0]   capture_trigger,
  output logic                                           external_interrupt_line_ten
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                                    ext_en;     // External bus mode
    logic                                    bus_16bit;  // 16-bit bus width
    logic                                    wslo_en;    // Low strobe enable
    logic                                    wshi_en;    // High strobe enable
    logic [pin_select_pkg::NUM_HI_ADDR-1:0]  hi_ctl;     // High address output control
    logic [pin_select_pkg::NUM_PINS-1:0]     pdata;      // Port data
    logic [pin_select_pkg::NUM_PINS-1:0]     pdir;       // Port direction
    logic [pin_select_pkg::NUM_PINS-1:0]     pull;       // Pull-up select
    logic [pin_select_pkg::NUM_PINS-1:0]     pin_out;    // Registered pad level
    logic [pin_select_pkg::NUM_PINS-1:0]     pin_oe;     // Registered drive enable
    logic [pin_select_pkg::NUM_PINS-1:0]     pin_pullup; // Registered pull-up
    logic [pin_select_pkg::NUM_CAPTURE-1:0]  capture;    // Capture taps
    logic                                    ext_int;    // Interrupt tap
    logic                                    pready;     // APB ready
    logic                                    pslverr;    // APB error
    logic [pin_select_pkg::DATA_W-1:0]       prdata;     // APB read data
    logic                                    alive;      // One after first edge past reset
  } state_t;

  state_t st;       // Registered state
  state_t next_st;  // Next state

  pin_sel_if sel ();  // Link to the multiplexer

  // ==========================================================
  // Address decode
  // Exact match only, so a misaligned byte address is unmapped
  // Read mux, write path and error flag share this compare,
  // so they never disagree on which addresses are mapped.
  function automatic logic hit(input logic [pin_select_pkg::ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Any implemented register
  function automatic logic mapped(input logic [pin_select_pkg::ADDR_W-1:0] a);
    mapped = hit(a, pin_select_pkg::OFF_CTRL) || hit(a, pin_select_pkg::OFF_HIGH_ADDRESS_OUTPUT_CONTROL) ||
             hit(a, pin_select_pkg::OFF_DATA) || hit(a, pin_select_pkg::OFF_DIR)  ||
             hit(a, pin_select_pkg::OFF_PULL) || hit(a, pin_select_pkg::OFF_PINS);
  endfunction

  // ==========================================================
  // Multiplexer hookup
  // Config comes from registers, strobes straight from the bus controller
  // Strobes are not registered on the way in: the pad flop is their only
  // stage, so a strobe reaches its pin one cycle after the controller.
  assign sel.ext_en    = st.ext_en;
  assign sel.bus_16bit = st.bus_16bit;
  assign sel.wslo_en   = st.wslo_en;
  assign sel.wshi_en   = st.wshi_en;
  assign sel.high_address_output_control = st.hi_ctl;
  assign sel.pdata     = st.pdata;
  assign sel.pdir      = st.pdir;
  assign sel.addr_hi   = bus_addr_hi;
  assign sel.ale       = bus_ale;
  assign sel.rd        = bus_rd;
  assign sel.write     = bus_write;
  assign sel.lane_lo   = bus_lane_lo;
  assign sel.lane_hi   = bus_lane_hi;

  // The mux is pure logic; next_st catches all of its outputs
  pin_mux u_mux (
    .sel (sel.mux)
  );

  // ==========================================================
  // Next-state logic
  // Setup cycle loads read data and error; the access cycle that
  // follows sees pready high, so every transfer has no wait state.
  // Limitation: a pin status read shows the pad levels of the setup
  // cycle, not of the access cycle.
  always_comb begin
    logic setup;
    logic access;
    logic [pin_select_pkg::DATA_W-1:0] rd_val;
    setup   = psel && !penable;
    access  = psel && penable && st.pready;
    rd_val  = '0;
    next_st = st;

    // Read mux, unused bits stay zero
    if (hit(paddr, pin_select_pkg::OFF_CTRL)) begin
      rd_val[pin_select_pkg::CTRL_EXT_BIT]  = st.ext_en;
      rd_val[pin_select_pkg::CTRL_B16_BIT]  = st.bus_16bit;
      rd_val[pin_select_pkg::CTRL_WSLO_BIT] = st.wslo_en;
      rd_val[pin_select_pkg::CTRL_WSHI_BIT] = st.wshi_en;
    end else if (hit(paddr, pin_select_pkg::OFF_HIGH_ADDRESS_OUTPUT_CONTROL)) begin
      rd_val[pin_select_pkg::NUM_HI_ADDR-1:0] = st.hi_ctl;
    end else if (hit(paddr, pin_select_pkg::OFF_DATA)) begin
      rd_val[pin_select_pkg::NUM_PINS-1:0] = st.pdata;
    end else if (hit(paddr, pin_select_pkg::OFF_DIR)) begin
      rd_val[pin_select_pkg::NUM_PINS-1:0] = st.pdir;
    end else if (hit(paddr, pin_select_pkg::OFF_PULL)) begin
      rd_val[pin_select_pkg::NUM_PINS-1:0] = st.pull;
    end else if (hit(paddr, pin_select_pkg::OFF_PINS)) begin
      // Pad levels are readable whatever function owns the pin
      rd_val[pin_select_pkg::NUM_PINS-1:0] = pin_in;
      rd_val[pin_select_pkg::PINS_OWN_LSB +: pin_select_pkg::NUM_PINS] = sel.sel_port;
    end else begin
      rd_val = '0;
    end

    // Bus handshake
    next_st.pready = setup;
    if (setup) begin
      next_st.prdata  = pwrite ? '0 : rd_val;
      next_st.pslverr = !mapped(paddr);
    end

    // Writes land only at the completing access edge
    if (access && pwrite) begin
      if (hit(paddr, pin_select_pkg::OFF_CTRL)) begin
        next_st.ext_en    = pwdata[pin_select_pkg::CTRL_EXT_BIT];
        next_st.bus_16bit = pwdata[pin_select_pkg::CTRL_B16_BIT];
        next_st.wslo_en   = pwdata[pin_select_pkg::CTRL_WSLO_BIT];
        next_st.wshi_en   = pwdata[pin_select_pkg::CTRL_WSHI_BIT];
      end
      if (hit(paddr, pin_select_pkg::OFF_HIGH_ADDRESS_OUTPUT_CONTROL)) begin
        next_st.hi_ctl = pwdata[pin_select_pkg::NUM_HI_ADDR-1:0];
      end
      if (hit(paddr, pin_select_pkg::OFF_DATA)) begin
        next_st.pdata = pwdata[pin_select_pkg::NUM_PINS-1:0];
      end
      if (hit(paddr, pin_select_pkg::OFF_DIR)) begin
        next_st.pdir = pwdata[pin_select_pkg::NUM_PINS-1:0];
      end
      if (hit(paddr, pin_select_pkg::OFF_PULL)) begin
        next_st.pull = pwdata[pin_select_pkg::NUM_PINS-1:0];
      end
    end

    // Pads: registered so the outputs are glitch free
    next_st.pin_out = sel.sel_out;
    next_st.pin_oe  = sel.sel_oe;
    // Pull-up only on a port-owned input; a driven pin gains nothing from it
    next_st.pin_pullup = st.pull & sel.sel_port & ~st.pdir;

    // Triggers read the pad whoever drives it
    next_st.capture = pin_in[pin_select_pkg::NUM_CAPTURE-1:0];
    next_st.ext_int = pin_in[pin_select_pkg::PIN_WSLO];
    next_st.alive   = 1'b1;
  end

  // ==========================================================
  // State register
  // Only configuration needs named reset values; the rest clears to
  // zero, which leaves every pad an undriven input during reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st            <= '0;
      st.ext_en     <= pin_select_pkg::CTRL_RST[pin_select_pkg::CTRL_EXT_BIT];
      st.bus_16bit  <= pin_select_pkg::CTRL_RST[pin_select_pkg::CTRL_B16_BIT];
      st.wslo_en    <= pin_select_pkg::CTRL_RST[pin_select_pkg::CTRL_WSLO_BIT];
      st.wshi_en    <= pin_select_pkg::CTRL_RST[pin_select_pkg::CTRL_WSHI_BIT];
      st.hi_ctl     <= pin_select_pkg::HIGH_ADDRESS_OUTPUT_CONTROL_RST;
      st.pdata      <= pin_select_pkg::DATA_RST;
      st.pdir       <= pin_select_pkg::DIR_RST;
      st.pull       <= pin_select_pkg::PULL_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, each straight from the state register
  // No logic between flop and port, so pad timing is one clock
  assign prdata                      = st.prdata;
  assign pready                      = st.pready;
  assign pslverr                     = st.pslverr;
  assign pin_out                     = st.pin_out;
  assign pin_oe                      = st.pin_oe;
  assign pin_pullup                  = st.pin_pullup;
  assign capture_trigger             = st.capture;
  assign external_interrupt_line_ten = st.ext_int;

  // ==========================================================
  // Assertions
  // Pads lag their cause by one edge, so each check looks one cycle back.
  // The alive flag masks the first edge after reset, whose past is reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Address pin with control bit set follows the port registers
  a_addr_port_own: assert property (
    st.alive && $past(st.ext_en && st.hi_ctl[0])
    |-> pin_out[0] == $past(st.pdata[0]) && pin_oe[0] == $past(st.pdir[0]))
    else $error("address pin not released to port");

  // Single-chip mode hands every address pin to the port registers
  a_addr_port_sc: assert property (
    st.alive && $past(!st.ext_en)
    |-> pin_oe[3:0] == $past(st.pdir[3:0]) && pin_out[3:0] == $past(st.pdata[3:0]))
    else $error("address pins not port in single-chip mode");

  // Address pin with control bit clear drives the bus address
  a_addr_bus_drive: assert property (
    st.alive && $past(st.ext_en && !st.hi_ctl[3])
    |-> pin_oe[3] && pin_out[3] == $past(bus_addr_hi[3]))
    else $error("high address bit not driven");

  // Single-chip mode keeps the read strobe pin as a port
  a_strobe_port_sc: assert property (
    st.alive && $past(!st.ext_en)
    |-> pin_oe[pin_select_pkg::PIN_RD] == $past(st.pdir[pin_select_pkg::PIN_RD]))
    else $error("read pin not port in single-chip mode");

  // Single-chip mode keeps the latch pin as a port too
  a_latch_port_sc: assert property (
    st.alive && $past(!st.ext_en)
    |-> pin_out[pin_select_pkg::PIN_ALE] == $past(st.pdata[pin_select_pkg::PIN_ALE]))
    else $error("latch pin not port in single-chip mode");

  // Bus mode drives the latch strobe
  a_latch_strobe: assert property (
    st.alive && $past(st.ext_en)
    |-> pin_oe[pin_select_pkg::PIN_ALE] && pin_out[pin_select_pkg::PIN_ALE] == $past(bus_ale))
    else $error("latch strobe not on pin");

  // Bus mode drives the read strobe
  a_read_strobe: assert property (
    st.alive && $past(st.ext_en)
    |-> pin_oe[pin_select_pkg::PIN_RD] && pin_out[pin_select_pkg::PIN_RD] == $past(bus_rd))
    else $error("read strobe not on pin");

  // Low strobe disabled returns the pin to the port
  a_wslo_port: assert property (
    st.alive && $past(st.ext_en && !st.wslo_en)
    |-> pin_out[pin_select_pkg::PIN_WSLO] == $past(st.pdata[pin_select_pkg::PIN_WSLO]))
    else $error("low write pin not port");

  // 8-bit bus: low strobe follows every write
  a_wslo_8bit: assert property (
    st.alive && $past(st.ext_en && st.wslo_en && !st.bus_16bit)
    |-> pin_oe[pin_select_pkg::PIN_WSLO] && pin_out[pin_select_pkg::PIN_WSLO] == $past(bus_write))
    else $error("low strobe wrong on 8-bit bus");

  // 16-bit bus: low strobe only for the low lane
  a_wslo_16bit: assert property (
    st.alive && $past(st.ext_en && st.wslo_en && st.bus_16bit)
    |-> pin_out[pin_select_pkg::PIN_WSLO] == $past(bus_write && bus_lane_lo))
    else $error("low strobe wrong on 16-bit bus");

  // High strobe missing one condition leaves the port in charge
  a_wshi_port: assert property (
    st.alive && $past(!(st.ext_en && st.bus_16bit && st.wshi_en))
    |-> pin_oe[pin_select_pkg::PIN_WSHI] == $past(st.pdir[pin_select_pkg::PIN_WSHI]))
    else $error("high write pin not port");

  // High strobe with all three conditions
  a_wshi_drive: assert property (
    st.alive && $past(st.ext_en && st.bus_16bit && st.wshi_en)
    |-> pin_oe[pin_select_pkg::PIN_WSHI] &&
        pin_out[pin_select_pkg::PIN_WSHI] == $past(bus_write && bus_lane_hi))
    else $error("high strobe wrong");

  // 8-bit bus: high write pin stays a port even when enabled
  a_wshi_8bit_port: assert property (
    st.alive && $past(st.ext_en && !st.bus_16bit && st.wshi_en)
    |-> pin_out[pin_select_pkg::PIN_WSHI] == $past(st.pdata[pin_select_pkg::PIN_WSHI]))
    else $error("high write pin not port on 8-bit bus");

  // Pull-up never on the latch pin while the bus owns it
  a_pull_bus_off: assert property (
    st.alive && $past(st.ext_en) |-> !pin_pullup[pin_select_pkg::PIN_ALE])
    else $error("pull-up on bus-owned pin");

  // A port-owned input with its select bit set gets the pull-up
  a_pull_port_on: assert property (
    st.alive && $past(!st.ext_en && st.pull[1] && !st.pdir[1]) |-> pin_pullup[1])
    else $error("pull-up missing on port input");

  // Capture taps copy the pads one edge later
  a_capture_tap: assert property (
    st.alive |-> capture_trigger == $past(pin_in[pin_select_pkg::NUM_CAPTURE-1:0]))
    else $error("capture tap wrong");

  // Interrupt tap works while the low strobe owns the pin
  a_int_tap: assert property (
    st.alive && $past(st.ext_en && st.wslo_en)
    |-> external_interrupt_line_ten == $past(pin_in[pin_select_pkg::PIN_WSLO]))
    else $error("interrupt tap lost");

  // Every access cycle completes at once
  a_apb_no_wait: assert property (
    psel && !penable |=> pready)
    else $error("APB ready late");

  // Ready is a one-cycle pulse
  a_apb_ready_pulse: assert property (
    pready |=> !pready)
    else $error("APB ready held");

  // Unmapped addresses answer with an error
  a_apb_err_unmapped: assert property (
    psel && !penable && !mapped(paddr) |=> pslverr)
    else $error("APB error missing");

endmodule // ext_bus_pin_select
`default_nettype wire

// [dv/pad_model.sv]
// Pad-side model: what the pins read back as, given what the block drives.
// Assumes an undriven pin without pull-up is left floating by the far side.
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  output logic      [7:0] pin_in
);
  logic [7:0] last = 8'h00;  // Last level driven per pin
  // ==========================================================
  // Remember driven levels so a released pin without pull-up never shows them again
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) if (pin_oe[i]) last[i] <= pin_out[i];
  end
  // Released pins float away from the last value unless pulled up
  always_comb begin
    for (int i = 0; i < 8; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pullup[i] ? 1'b1 : ~last[i]);
  end
endmodule // pad_model
`default_nettype wire

// [dv/external_bus_pin_function_select_test.sv]
// Testbench: APB master, random pin configurations, expected pin functions.
// Assumes the pad model closes the loop from pin outputs to pin inputs.
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_function_select_test;
  logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, external_interrupt_line_ten;
  logic [3:0]  bus_addr_hi = 4'h0;
  logic        bus_ale = 1'b0, bus_rd = 1'b0, bus_write = 1'b0, bus_lane_lo = 1'b0, bus_lane_hi = 1'b0;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup;
  logic [5:0]  capture_trigger;
  int          errors = 0, n_compared = 0;
  ext_bus_pin_select i_ext_bus_pin_select (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_addr_hi, .bus_ale, .bus_rd, .bus_write, .bus_lane_lo, .bus_lane_hi,
    .pin_in, .pin_out, .pin_oe, .pin_pullup, .capture_trigger, .external_interrupt_line_ten);
  pad_model i_pad_model (.sys_clk, .pin_out, .pin_oe, .pin_pullup, .pin_in);
  // ==========================================================
  // Clock and watchdog; a hang counts as a mismatch
  initial forever #20 sys_clk = ~sys_clk;
  initial begin
    #(40 * 20000);
    errors++;
    close_out();
  end
  task automatic close_out();
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ==========================================================
  // One APB transfer, entered just after a rising edge; waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    check("pready wait", 32'(n), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Expected {owner, pull-up, enable, level} from configuration and bus strobes
  function automatic logic [31:0] exp_pins(logic [3:0] c, h, logic [7:0] d, dr, pu, logic [8:0] b);
    logic [7:0] own, o;
    own = 8'hff;
    for (int i = 0; i < 4; i++) if (c[0] && !h[i]) own[i] = 1'b0;
    if (c[0]) own[5:4] = 2'b00;
    if (c[0] && c[2]) own[6] = 1'b0;
    if (c[0] && c[1] && c[3]) own[7] = 1'b0;
    o = {b[6] & b[8], c[1] ? b[6] & b[7] : b[6], b[5], b[4], b[3:0]};
    return {own, own & pu & ~dr, (own & dr) | ~own, (own & d) | (~own & o)};
  endfunction
  // ==========================================================
  // Main sequence: reset values, refused addresses, random configurations
  initial begin
    logic [31:0] r, x, e;
    logic        er;
    logic [3:0]  c;
    logic [3:0]  corner [4] = '{4'h0, 4'hd, 4'hf, 4'h5};
    void'($urandom(32'ha5c1da24));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0, r, er);
      check("reset value", r, 32'h0);
    end
    foreach (corner[k]) if (k < 2) begin
      apb(1'b1, k == 0 ? 8'h18 : 8'h02, 32'hffff_ffff, r, er);
      check("refused error", 32'(er), 32'h1);
      check("refused data", r, 32'h0);
    end
    for (int it = 0; it < 60; it++) begin
      x = $urandom;
      c = it < 4 ? corner[it] : x[3:0];
      apb(1'b1, pin_select_pkg::OFF_CTRL, 32'(c), r, er);
      apb(1'b1, pin_select_pkg::OFF_HIGH_ADDRESS_OUTPUT_CONTROL, 32'(x[7:4]), r, er);
      apb(1'b1, pin_select_pkg::OFF_DATA, 32'(x[15:8]), r, er);
      apb(1'b1, pin_select_pkg::OFF_DIR, 32'(x[23:16]), r, er);
      apb(1'b1, pin_select_pkg::OFF_PULL, 32'(x[31:24]), r, er);
      apb(1'b0, pin_select_pkg::OFF_CTRL, 32'h0, r, er);
      check("ctrl readback", r, 32'(c));
      check("ctrl error", 32'(er), 32'h0);
      e = $urandom;
      {bus_lane_hi, bus_lane_lo, bus_write, bus_rd, bus_ale, bus_addr_hi} <= e[8:0];
      e = exp_pins(c, x[7:4], x[15:8], x[23:16], x[31:24], e[8:0]);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check("pin_out", 32'(pin_out), 32'(e[7:0]));
      check("pin_oe", 32'(pin_oe), 32'(e[15:8]));
      check("pin_pullup", 32'(pin_pullup), 32'(e[23:16]));
      check("capture", 32'(capture_trigger), 32'(pin_in[5:0]));
      check("interrupt tap", 32'(external_interrupt_line_ten), 32'(pin_in[6]));
      @(posedge sys_clk);
      apb(1'b0, pin_select_pkg::OFF_PINS, 32'h0, r, er);
      check("pin status", r, {16'h0, e[31:24], pin_in});
    end
    close_out();
  end
endmodule // external_bus_pin_function_select_test
`default_nettype wire
